// [mpls_rewriter_regs.vh]
// register offsets, field layout and constants of the mpls rewriter
`ifndef MPLS_REWRITER_REGS_VH
`define MPLS_REWRITER_REGS_VH

// ----------------------------------------------------------------
// apb address split: entry index and word within the entry
// ----------------------------------------------------------------
`define AW_IDX 15:6
`define AW_WORD 5:2
`define AW_LSEL 1:0

// ----------------------------------------------------------------
// word offsets within one encapsulation entry
// ----------------------------------------------------------------
`define A_DMAC_HI 4'h0
`define A_DMAC_LO 4'h1
`define A_SMAC_HI 4'h2
`define A_SMAC_LO 4'h3
`define A_ETYPE 4'h4
`define A_LCFG 4'h5
`define A_CWORD 4'h6
`define A_OCFG 4'h7
`define A_LAB0 4'h8
`define A_LAB1 4'h9
`define A_LAB2 4'ha
`define A_OVAL 4'hb
`define A_RSEL0 4'hc
`define A_RSEL1 4'hd
`define A_RSEL2 4'he
`define A_STATUS 4'hf

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LC_INNER 0
`define LC_CNT 2:1
`define LC_CW 3
`define OC_EN 0
`define OC_POS 1
`define OC_TC 4:2
`define LW_LBL 31:12
`define LW_TC 11:9
`define LW_LOW 8:0

// ----------------------------------------------------------------
// encodings and sizes
// ----------------------------------------------------------------
`define MAX_POP 6'h2a
`define LINK_BYTES 5'h0e
`define HDR_TOP 8'hef
`define PDU_TP_OAM 2'h1
`define PDU_Y1731 2'h2
`define TC_CLS 3'h0
`define TC_M0 3'h4
`define TC_M1 3'h5
`define TC_M2 3'h6
`define TC_M3 3'h7

`endif

// [mpls_pop_and_encap_rewriter.v]
// egress mpls pop and encapsulation push with apb table access
`timescale 1ns/100ps
`default_nettype none
`include "mpls_rewriter_regs.vh"
// Operation
// - pop count is classifier's unless lookup hits with non-zero count, then min
// - never pop more than 42 bytes from the frame start
// - entry chosen by lookup index; index zero never pushes
// - each entry holds destination mac as upper 16 and lower 32 bits
// - each entry holds source mac halves and a 16-bit ethertype
// - inner-select bit takes innermost label value from the lookup
// - push as many labels as the entry's count, at most three
// - control word enable inserts 32-bit word after the label stack
// - oam label inserted for transport oam, or y1731 after control word
// - oam label never inserted together with a control word
// - position bit: 0 before last label, 1 after last label
// - oam tc selector: classified, configured, or mapping tables
// - entry stores value, tc, s-bit and ttl for three labels
// - entry stores value, tc, s-bit and ttl of the oam label
// - label selector: 0 stored value, 4 to 7 mapping tables
// - order: lookup with table lookup, then pop, then push
// - without lookup hit only popping is done
module mpls_pop_and_encap_rewriter #(
    parameter ENTRIES = 1024
) (
    input wire ref_clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire in_valid,
    output reg in_ready,
    input wire [7:0] in_data,
    input wire in_first,
    input wire in_last,
    input wire lookup_hit,
    input wire [5:0] lookup_pop_count,
    input wire [5:0] classifier_pop_count,
    input wire [9:0] encapsulation_index,
    input wire [19:0] lookup_inner_label,
    input wire [1:0] frame_pdu_kind,
    input wire type_after_pop_cw,
    input wire [2:0] classified_tc,
    input wire [11:0] map_tc,
    input wire [3:0] map_tc_hit,
    input wire [79:0] map_label,
    output reg out_valid,
    input wire out_ready,
    output reg [7:0] out_data,
    output reg out_first,
    output reg out_last
);

localparam S_IDLE = 5'h01;
localparam S_LOOK = 5'h02;
localparam S_POP = 5'h04;
localparam S_HDR = 5'h08;
localparam S_PASS = 5'h10;

// ----------------------------------------------------------------
// encapsulation table
// ----------------------------------------------------------------
reg [15:0] dh_mem [0:ENTRIES-1];
reg [31:0] dl_mem [0:ENTRIES-1];
reg [15:0] sh_mem [0:ENTRIES-1];
reg [31:0] sl_mem [0:ENTRIES-1];
reg [15:0] et_mem [0:ENTRIES-1];
reg [3:0] lc_mem [0:ENTRIES-1];
reg [31:0] cw_mem [0:ENTRIES-1];
reg [4:0] oc_mem [0:ENTRIES-1];
reg [31:0] ov_mem [0:ENTRIES-1];
reg [31:0] lab_mem [0:ENTRIES*4-1];
reg [2:0] rs_mem [0:ENTRIES*4-1];

wire [9:0] a_idx = paddr[`AW_IDX];
wire [3:0] a_word = paddr[`AW_WORD];
wire [11:0] a_lab = {a_idx, a_word[`AW_LSEL]};
wire apb_setup = psel & ~penable;
wire apb_wr = psel & penable & pwrite & pready;

reg [4:0] state_r, state_nxt;
reg [15:0] frames_r, frames_nxt;
reg [31:0] rd_nxt;

always @* begin
    case (a_word)
        `A_DMAC_HI: rd_nxt = {16'h0000, dh_mem[a_idx]};
        `A_DMAC_LO: rd_nxt = dl_mem[a_idx];
        `A_SMAC_HI: rd_nxt = {16'h0000, sh_mem[a_idx]};
        `A_SMAC_LO: rd_nxt = sl_mem[a_idx];
        `A_ETYPE: rd_nxt = {16'h0000, et_mem[a_idx]};
        `A_LCFG: rd_nxt = {28'h0000000, lc_mem[a_idx]};
        `A_CWORD: rd_nxt = cw_mem[a_idx];
        `A_OCFG: rd_nxt = {27'h0000000, oc_mem[a_idx]};
        `A_LAB0, `A_LAB1, `A_LAB2: rd_nxt = lab_mem[a_lab];
        `A_OVAL: rd_nxt = ov_mem[a_idx];
        `A_RSEL0, `A_RSEL1, `A_RSEL2:
            rd_nxt = {29'h00000000, rs_mem[a_lab]};
        `A_STATUS: rd_nxt = {11'h000, state_r, frames_r};
        default: rd_nxt = 32'h00000000;
    endcase
end

// table writes never touch the per-frame snapshot below
always @(posedge ref_clk) begin
    if (apb_wr) begin
        case (a_word)
            `A_DMAC_HI: dh_mem[a_idx] <= pwdata[15:0];
            `A_DMAC_LO: dl_mem[a_idx] <= pwdata;
            `A_SMAC_HI: sh_mem[a_idx] <= pwdata[15:0];
            `A_SMAC_LO: sl_mem[a_idx] <= pwdata;
            `A_ETYPE: et_mem[a_idx] <= pwdata[15:0];
            `A_LCFG: lc_mem[a_idx] <= pwdata[3:0];
            `A_CWORD: cw_mem[a_idx] <= pwdata;
            `A_OCFG: oc_mem[a_idx] <= pwdata[4:0];
            `A_LAB0, `A_LAB1, `A_LAB2: lab_mem[a_lab] <= pwdata;
            `A_OVAL: ov_mem[a_idx] <= pwdata;
            `A_RSEL0, `A_RSEL1, `A_RSEL2: rs_mem[a_lab] <= pwdata[2:0];
            default: ;
        endcase
    end
end

// ----------------------------------------------------------------
// per-frame snapshot, taken at the lookup
// ----------------------------------------------------------------
wire take = (state_r == S_IDLE) & in_valid & in_first;
wire use_lk = lookup_hit & (lookup_pop_count != 6'h00) &
    (lookup_pop_count < classifier_pop_count);
wire [5:0] lk_pop = use_lk ? lookup_pop_count : classifier_pop_count;
wire [5:0] pop_eff = (lk_pop > `MAX_POP) ? `MAX_POP : lk_pop;

reg hit_s, tap_s;
reg [5:0] pop_s;
reg [15:0] dh_s, sh_s, et_s;
reg [31:0] dl_s, sl_s, cwv_s, ov_s;
reg [3:0] lc_s, mhit_s;
reg [4:0] oc_s;
reg [31:0] lab_s [0:2];
reg [2:0] rs_s [0:2];
reg [19:0] inner_s;
reg [1:0] pdu_s;
reg [2:0] ctc_s;
reg [11:0] mtc_s;
reg [79:0] mlab_s;

genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : g_lab
        localparam [1:0] LAB_POS = g;
        always @(posedge ref_clk) begin
            if (take) begin
                lab_s[g] <= lab_mem[{encapsulation_index, LAB_POS}];
                rs_s[g] <= rs_mem[{encapsulation_index, LAB_POS}];
            end
        end
    end
endgenerate

always @(posedge ref_clk) begin
    if (take) begin
        hit_s <= lookup_hit & (encapsulation_index != 10'h000);
        pop_s <= pop_eff;
        dh_s <= dh_mem[encapsulation_index];
        dl_s <= dl_mem[encapsulation_index];
        sh_s <= sh_mem[encapsulation_index];
        sl_s <= sl_mem[encapsulation_index];
        et_s <= et_mem[encapsulation_index];
        lc_s <= lc_mem[encapsulation_index];
        cwv_s <= cw_mem[encapsulation_index];
        oc_s <= oc_mem[encapsulation_index];
        ov_s <= ov_mem[encapsulation_index];
        inner_s <= lookup_inner_label;
        pdu_s <= frame_pdu_kind;
        tap_s <= type_after_pop_cw;
        ctc_s <= classified_tc;
        mtc_s <= map_tc;
        mhit_s <= map_tc_hit;
        mlab_s <= map_label;
    end
end

// ----------------------------------------------------------------
// header construction
// ----------------------------------------------------------------
function [31:0] mk_label;
    input [31:0] stored;
    input [2:0] sel;
    input [79:0] ml;
    begin
        mk_label = stored;
        if (sel[2])
            mk_label[`LW_LBL] = ml[sel[1:0]*20 +: 20];
    end
endfunction

// odd selectors fall back to the even table, even ones to the value
function [2:0] oam_tc;
    input [2:0] sel;
    input [2:0] cls;
    input [2:0] cfg;
    input [11:0] mt;
    input [3:0] mh;
    reg [2:0] base;
    begin
        base = mh[{sel[1], 1'b0}] ? mt[{sel[1], 1'b0}*3 +: 3] : cfg;
        case (sel)
            `TC_CLS: oam_tc = cls;
            `TC_M0, `TC_M2: oam_tc = base;
            `TC_M1, `TC_M3:
                oam_tc = mh[{sel[1], 1'b1}] ?
                    mt[{sel[1], 1'b1}*3 +: 3] : base;
            default: oam_tc = cfg;
        endcase
    end
endfunction

reg [127:0] words;
reg [239:0] hdr_vec;
reg [4:0] hdr_len;
reg [31:0] lw;
reg [1:0] cnt;
integer i, k;
wire oam_ins = oc_s[`OC_EN] & ~lc_s[`LC_CW] &
    ((pdu_s == `PDU_TP_OAM) | ((pdu_s == `PDU_Y1731) & tap_s));
wire [2:0] otc = oam_tc(oc_s[`OC_TC], ctc_s, ov_s[`LW_TC], mtc_s,
    mhit_s);
wire [31:0] oam_w = {ov_s[`LW_LBL], otc, ov_s[`LW_LOW]};

always @* begin
    words = 128'h0;
    lw = 32'h00000000;
    k = 0;
    cnt = lc_s[`LC_CNT];
    for (i = 0; i < 3; i = i + 1) begin
        if (i < cnt) begin
            if (oam_ins && !oc_s[`OC_POS] && i == cnt - 1) begin
                words[127 - 32*k -: 32] = oam_w;
                k = k + 1;
            end
            lw = mk_label(lab_s[i], rs_s[i], mlab_s);
            if (i == cnt - 1 && lc_s[`LC_INNER])
                lw[`LW_LBL] = inner_s;
            words[127 - 32*k -: 32] = lw;
            k = k + 1;
        end
    end
    // with no labels there is no last label to stand before
    if (oam_ins && (oc_s[`OC_POS] || cnt == 2'h0)) begin
        words[127 - 32*k -: 32] = oam_w;
        k = k + 1;
    end
    if (lc_s[`LC_CW]) begin
        words[127 - 32*k -: 32] = cwv_s;
        k = k + 1;
    end
    hdr_vec = {dh_s, dl_s, sh_s, sl_s, et_s, words};
    hdr_len = hit_s ? `LINK_BYTES + {k[2:0], 2'b00} : 5'h00;
end

// ----------------------------------------------------------------
// frame sequencer and two-entry output buffer
// ----------------------------------------------------------------
reg [5:0] pop_left_r, pop_left_nxt;
reg [4:0] idx_r, idx_nxt;
reg first_r, first_nxt;
reg tail_v_r;
reg [9:0] tail_r;
reg push;
reg [9:0] pw;
reg hv, tv;
reg [9:0] hd, td;
wire acc = in_valid & in_ready;
wire pop_o = out_valid & out_ready;
wire [7:0] hdr_byte = hdr_vec[`HDR_TOP - {idx_r, 3'b000} -: 8];
wire [4:0] go_after_pop = (hdr_len != 5'h00) ? S_HDR : S_PASS;

always @* begin
    state_nxt = state_r;
    pop_left_nxt = pop_left_r;
    idx_nxt = idx_r;
    first_nxt = first_r;
    frames_nxt = frames_r;
    push = 1'b0;
    pw = 10'h000;
    case (state_r)
        S_IDLE: begin
            if (take)
                state_nxt = S_LOOK;
        end
        S_LOOK: begin
            pop_left_nxt = pop_s;
            idx_nxt = 5'h00;
            first_nxt = 1'b1;
            state_nxt = (pop_s != 6'h00) ? S_POP : go_after_pop;
        end
        S_POP: begin
            if (acc) begin
                pop_left_nxt = pop_left_r - 6'h01;
                // a frame shorter than the pop count vanishes whole
                if (in_last)
                    state_nxt = S_IDLE;
                else if (pop_left_r == 6'h01)
                    state_nxt = go_after_pop;
            end
        end
        S_HDR: begin
            if (!tail_v_r) begin
                push = 1'b1;
                pw = {first_r, 1'b0, hdr_byte};
                first_nxt = 1'b0;
                idx_nxt = idx_r + 5'h01;
                if (idx_r == hdr_len - 5'h01)
                    state_nxt = S_PASS;
            end
        end
        S_PASS: begin
            if (acc) begin
                push = 1'b1;
                pw = {first_r, in_last, in_data};
                first_nxt = 1'b0;
                if (in_last) begin
                    state_nxt = S_IDLE;
                    frames_nxt = frames_r + 16'h0001;
                end
            end
        end
        default: state_nxt = S_IDLE;
    endcase
    hv = out_valid;
    tv = tail_v_r;
    hd = {out_first, out_last, out_data};
    td = tail_r;
    if (pop_o || !out_valid) begin
        if (tail_v_r) begin
            hd = tail_r;
            hv = 1'b1;
            tv = push;
            if (push)
                td = pw;
        end else begin
            hv = push;
            if (push)
                hd = pw;
        end
    end else if (push) begin
        td = pw;
        tv = 1'b1;
    end
end

always @(posedge ref_clk) begin
    if (srst) begin
        state_r <= S_IDLE;
        frames_r <= 16'h0000;
        pop_left_r <= 6'h00;
        idx_r <= 5'h00;
        first_r <= 1'b0;
        tail_v_r <= 1'b0;
        tail_r <= 10'h000;
        out_valid <= 1'b0;
        out_first <= 1'b0;
        out_last <= 1'b0;
        out_data <= 8'h00;
        in_ready <= 1'b0;
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else begin
        state_r <= state_nxt;
        frames_r <= frames_nxt;
        pop_left_r <= pop_left_nxt;
        idx_r <= idx_nxt;
        first_r <= first_nxt;
        tail_v_r <= tv;
        tail_r <= td;
        out_valid <= hv;
        {out_first, out_last, out_data} <= hd;
        // ready is the next cycle's acceptance, kept in a flop
        in_ready <= (state_nxt == S_POP) | ((state_nxt == S_PASS) & ~tv);
        pready <= apb_setup;
        pslverr <= apb_setup & pwrite & (a_word == `A_STATUS);
        if (apb_setup)
            prdata <= rd_nxt;
    end
end

endmodule // mpls_pop_and_encap_rewriter
`default_nettype wire

// [rewriter_checker_assertions.sv]
// port-level assertions for the mpls pop and encapsulation rewriter
`timescale 1ns/100ps
`default_nettype none
module rewriter_checker (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic in_first,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [7:0] out_data,
    input wire logic out_first,
    input wire logic out_last
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_access;
        psel && penable && pready;
    endsequence
    answer_next_a: assert property (apb_setup |=> apb_access)
        else $error("no access answer after setup");
    answer_once_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    answer_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    status_refuse_a: assert property (apb_access ##0
        (pwrite && paddr[5:2] == 4'hf) |-> pslverr)
        else $error("status write not refused");
    refuse_cause_a: assert property (pslverr |->
        pready && pwrite && paddr[5:2] == 4'hf)
        else $error("spurious pslverr");
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid &&
        $stable({out_data, out_first, out_last}))
        else $error("stalled output byte changed");
    reset_quiet_a: assert property ($fell(srst) |->
        !out_valid && !in_ready && !pready && !pslverr)
        else $error("outputs active after reset");
    lookup_first_a: assert property ($rose(in_valid) && in_first |->
        !in_ready ##1 !in_ready)
        else $error("byte taken before lookup");
endmodule // rewriter_checker

bind mpls_pop_and_encap_rewriter rewriter_checker chk (.ref_clk, .srst,
    .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .in_valid,
    .in_ready, .in_first, .out_valid, .out_ready, .out_data, .out_first,
    .out_last);
`default_nettype wire

// [frame_partner.sv]
// upstream byte source and egress sink model facing the rewriter
`timescale 1ns/100ps
`default_nettype none
module frame_partner (
    input wire logic ref_clk,
    input wire logic in_ready,
    output logic in_valid,
    output logic [7:0] in_data,
    output logic in_first,
    output logic in_last,
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [7:0] out_data,
    input wire logic out_first,
    input wire logic out_last
);
    logic [9:0] got[$];
    logic slow = 1'b0;
    logic [1:0] tick = 2'h0;
    initial begin
        in_valid = 1'b0;
        in_data = 8'h00;
        in_first = 1'b0;
        in_last = 1'b0;
        out_ready = 1'b0;
    end
    // each byte held until the rewriter takes it
    task automatic send(input logic [7:0] b[$]);
        @(posedge ref_clk);
        for (int i = 0; i < b.size(); i++) begin
            in_valid <= 1'b1;
            in_data <= b[i];
            in_first <= (i == 0);
            in_last <= (i == b.size() - 1);
            do @(posedge ref_clk); while (!in_ready);
        end
        in_valid <= 1'b0;
        in_data <= ~b[b.size() - 1];
    endtask
    // slow mode takes one byte in four, to fill the output buffer
    always @(posedge ref_clk) begin
        tick <= tick + 2'h1;
        out_ready <= !slow || tick == 2'h3;
        if (out_valid && out_ready)
            got.push_back({out_first, out_last, out_data});
    end
endmodule // frame_partner
`default_nettype wire

// [mpls_pop_and_encap_rewriter_bench.sv]
// self-checking bench for the mpls pop and encapsulation rewriter
`timescale 1ns/100ps
`default_nettype none
`include "mpls_rewriter_regs.vh"
module mpls_pop_and_encap_rewriter_bench;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, in_valid, in_ready, in_first, in_last;
    logic [7:0] in_data, out_data;
    logic out_valid, out_ready, out_first, out_last;
    logic lookup_hit = 1'b0;
    logic [5:0] lookup_pop_count = 6'h00, classifier_pop_count = 6'h00;
    logic [9:0] encapsulation_index = 10'h000;
    logic [19:0] lookup_inner_label = 20'habcde;
    logic [1:0] frame_pdu_kind = 2'h1;
    logic type_after_pop_cw = 1'b0;
    logic [2:0] classified_tc = 3'h2;
    logic [11:0] map_tc = 12'h000;
    logic [3:0] map_tc_hit = 4'h0;
    logic [79:0] map_label = 80'h0;
    logic [9:0] exp_q[$];
    logic [31:0] tbl[15] = '{32'h1122, 32'h33445566, 32'h7788,
        32'h99aabbcc, 32'h8847, 32'hb, 32'h0badcafe, 32'h1, 32'h12345a40,
        32'h0, 32'h0, 32'h0000d3ff, 32'h0, 32'h0, 32'h0};
    int errors = 0, checks_done = 0, cycles = 0, frames = 0;

    mpls_pop_and_encap_rewriter DUT (.ref_clk, .srst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid,
        .in_ready, .in_data, .in_first, .in_last, .lookup_hit,
        .lookup_pop_count, .classifier_pop_count, .encapsulation_index,
        .lookup_inner_label, .frame_pdu_kind, .type_after_pop_cw,
        .classified_tc, .map_tc, .map_tc_hit, .map_label, .out_valid,
        .out_ready, .out_data, .out_first, .out_last);
    frame_partner far (.ref_clk, .in_ready, .in_valid, .in_data,
        .in_first, .in_last, .out_valid, .out_ready, .out_data,
        .out_first, .out_last);

    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            finish_test;
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] ad(input logic [3:0] w);
        return {10'h001, w, 2'h0};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (!pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic put(input logic [47:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            exp_q.push_back({2'b00, v[8*i +: 8]});
    endtask
    // header bytes already queued; the surviving payload follows
    task automatic run(input logic h, input logic [9:0] ix,
                       input logic [5:0] lp, input logic [5:0] cp,
                       input int len, input logic [7:0] s, input int pop);
        logic [7:0] fb[$];
        for (int i = 0; i < len; i++)
            fb.push_back(8'(s + i));
        for (int i = pop; i < len; i++)
            exp_q.push_back({2'b00, 8'(s + i)});
        exp_q[0][9] = 1'b1;
        exp_q[exp_q.size() - 1][8] = 1'b1;
        lookup_hit <= h;
        encapsulation_index <= ix;
        lookup_pop_count <= lp;
        classifier_pop_count <= cp;
        far.send(fb);
        while (far.got.size() < exp_q.size())
            @(posedge ref_clk);
        check(far.got.size(), exp_q.size());
        foreach (exp_q[i])
            check(far.got[i], exp_q[i]);
        far.got = {};
        exp_q = {};
        frames++;
        $display("frame test %0d done", frames);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (int w = 0; w < 15; w++)
            apb(1'b1, ad(4'(w)), tbl[w]);
        apb(1'b1, ad(`A_STATUS), 32'hffff);
        check(err, 1'b1);
        for (int w = 0; w < 15; w++) begin
            apb(1'b0, ad(4'(w)), 32'h0);
            check(rd, tbl[w]);
        end
        $display("register test done");
        run(1'b0, 10'h001, 6'h05, 6'h02, 4, 8'h20, 2);
        run(1'b1, 10'h000, 6'h00, 6'h02, 4, 8'h30, 2);
        run(1'b0, 10'h001, 6'h00, 6'h3f, 45, 8'h40, 42);
        put({tbl[0][15:0], tbl[1]}, 6);
        put({tbl[2][15:0], tbl[3]}, 6);
        put(tbl[4], 2);
        put({20'habcde, tbl[8][11:0]}, 4);
        put(tbl[6], 4);
        far.slow = 1'b1;
        run(1'b1, 10'h001, 6'h01, 6'h03, 5, 8'h50, 1);
        far.slow = 1'b0;
        apb(1'b1, ad(`A_LCFG), 32'h2);
        apb(1'b1, ad(`A_OCFG), 32'h7);
        put({tbl[0][15:0], tbl[1]}, 6);
        put({tbl[2][15:0], tbl[3]}, 6);
        put(tbl[4], 2);
        put(tbl[8], 4);
        put(tbl[11], 4);
        run(1'b1, 10'h001, 6'h00, 6'h02, 3, 8'h60, 2);
        // three labels, oam label before the last, y1731 after a control word
        apb(1'b1, ad(`A_LCFG), 32'h6);
        apb(1'b1, ad(`A_OCFG), 32'h15);
        apb(1'b1, ad(`A_LAB1), 32'h55555f01);
        apb(1'b1, ad(`A_LAB2), 32'h66666e02);
        apb(1'b1, ad(`A_RSEL1), 32'h5);
        frame_pdu_kind <= 2'h2;
        type_after_pop_cw <= 1'b1;
        map_tc <= 12'h030;
        map_tc_hit <= 4'h2;
        map_label <= {20'h44444, 20'h33333, 20'h22222, 20'h11111};
        put({tbl[0][15:0], tbl[1]}, 6);
        put({tbl[2][15:0], tbl[3]}, 6);
        put(tbl[4], 2);
        put(tbl[8], 4);
        put(32'h22222f01, 4);
        put(32'h0000ddff, 4);
        put(32'h66666e02, 4);
        run(1'b1, 10'h001, 6'h00, 6'h02, 3, 8'h70, 2);
        apb(1'b0, ad(`A_STATUS), 32'h0);
        check({16'h0, rd[15:0]}, 32'd6);
        $display("status test done");
        finish_test;
    end
endmodule // mpls_pop_and_encap_rewriter_bench
`default_nettype wire
